// ### rtl/cct_timer.sv
// Eight-channel capture/compare timer with pulse accumulator
`default_nettype none

module cct_timer
  import cct_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          rst_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [15:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [15:0]   rdata_o,
  input  wire logic          freeze_i,
  input  wire logic          wait_mode_i,
  input  wire logic [7:0]    channel_pin_i,
  output logic      [7:0]    channel_pin_o,
  output logic      [7:0]    channel_pin_oe_o,
  output logic               irq_o
);

  typedef struct packed {
    logic [7:0]          sync1;
    logic [7:0]          sync2;
    logic [7:0]          pin_prev;
    logic [7:0]          func_sel;
    logic [7:0]          sys_ctrl;
    logic [15:0]         out_act;
    logic [15:0]         edge_sel;
    logic [IRQ_W-1:0]    irq_mask;
    logic [IRQ_W-1:0]    irq_stat;
    logic [2:0]          prescale;
    logic [7:0]          acc_ctrl;
    logic [15:0]         acc_count;
    logic [15:0]         counter;
    logic [NUM_CH-1:0][15:0] ch_val;
    logic [7:0]          pin_out;
    logic [7:0]          pin_oe;
    logic [1:0]          mode_sync1;
    logic [1:0]          mode_sync2;
    logic [15:0]         rdata;
    logic                irq;
  } cct_state_t;

  cct_state_t   st;
  cct_state_t   next_st;
  cct_bus_req_t req;
  cct_mode_t    mode;
  logic         run;
  logic         tick;
  logic [IRQ_W-1:0] events;
  logic         acc_in;
  logic         acc_prev;
  logic         ch_sel;
  logic [2:0]   ch_idx;

  assign req  = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign mode = '{freeze: st.mode_sync2[1], wait_mode: st.mode_sync2[0]};

  // Halt conditions; stop mode needs no logic since the clock itself stops
  assign run = st.sys_ctrl[RUN_EN_BIT]                         // [R13] [R10]
             & ~(mode.freeze & st.sys_ctrl[FRZ_STOP_BIT])      // [R11]
             & ~(mode.wait_mode & st.sys_ctrl[WAIT_STOP_BIT]); // [R12]

  cct_prescaler u_prescaler (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .run_i     (run),
    .factor_i  (st.prescale),
    .tick_o    (tick)
  );

  assign ch_sel   = (req.addr[7:4] == OFS_CH_BASE[7:4]) & ~req.addr[0];
  assign ch_idx   = req.addr[3:1];
  assign acc_in   = st.sync2[7];  // [R6] [R7]
  assign acc_prev = st.pin_prev[7];

  always_comb begin
    next_st = st;
    events  = '0;
    next_st.sync1      = channel_pin_i; // [R8]
    next_st.sync2      = st.sync1;
    next_st.pin_prev   = st.sync2;
    next_st.mode_sync1 = {freeze_i, wait_mode_i};
    next_st.mode_sync2 = st.mode_sync1;

    if (tick) begin
      next_st.counter = st.counter + 16'h0001; // [R1] [R15]
      if (st.counter == CNT_MAX) begin
        events[IRQ_OVF_BIT] = 1'b1;
      end
    end

    for (int i = 0; i < NUM_CH; i++) begin // [R2]
      if (st.func_sel[i]) begin // [R14]
        // Compare only on a tick so a match fires once per counter value
        if (tick && (st.counter + 16'h0001) == st.ch_val[i]) begin
          events[i] = 1'b1; // [R4]
          unique case (cct_out_act_t'(st.out_act[2*i +: 2]))
            CCT_OUT_NONE:   next_st.pin_out[i] = st.pin_out[i];
            CCT_OUT_TOGGLE: next_st.pin_out[i] = ~st.pin_out[i];
            CCT_OUT_CLEAR:  next_st.pin_out[i] = 1'b0;
            CCT_OUT_SET:    next_st.pin_out[i] = 1'b1;
          endcase
        end
        next_st.pin_oe[i] = (st.out_act[2*i +: 2] != CCT_OUT_NONE);
      end else begin
        next_st.pin_oe[i] = 1'b0;
        if (st.sys_ctrl[RUN_EN_BIT]
            && edge_hit(st.edge_sel[2*i +: 2], st.pin_prev[i], st.sync2[i])) begin
          next_st.ch_val[i] = st.counter; // [R3]
          events[i] = 1'b1;
        end
      end
    end

    // Pulse accumulator
    if (st.acc_ctrl[ACC_EN_BIT]) begin
      if (!st.acc_ctrl[ACC_MODE_BIT]) begin
        if (edge_hit({~st.acc_ctrl[ACC_EDGE_BIT], st.acc_ctrl[ACC_EDGE_BIT]},
                     acc_prev, acc_in)) begin
          next_st.acc_count = st.acc_count + 16'h0001; // [R5] [R6]
          events[IRQ_ACC_BIT] = 1'b1;
          events[IRQ_AOV_BIT] = (st.acc_count == CNT_MAX);
        end
      end else begin
        // Gated mode counts prescaler ticks while the gate level is active
        if (tick && (acc_in != st.acc_ctrl[ACC_EDGE_BIT])) begin
          next_st.acc_count = st.acc_count + 16'h0001; // [R5]
          events[IRQ_AOV_BIT] = (st.acc_count == CNT_MAX);
        end
        // Flag on the gate's closing edge
        if (edge_hit({~st.acc_ctrl[ACC_EDGE_BIT], st.acc_ctrl[ACC_EDGE_BIT]},
                     acc_prev, acc_in)) begin
          events[IRQ_ACC_BIT] = 1'b1;
        end
      end
    end

    // Register writes, full 16-bit width for counters
    if (req.wr) begin
      unique case (req.addr)
        OFS_FUNC_SEL:  next_st.func_sel = req.wdata[7:0];
        OFS_FORCE: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (req.wdata[i] && st.func_sel[i]) begin
              unique case (cct_out_act_t'(st.out_act[2*i +: 2]))
                CCT_OUT_NONE:   next_st.pin_out[i] = st.pin_out[i];
                CCT_OUT_TOGGLE: next_st.pin_out[i] = ~st.pin_out[i];
                CCT_OUT_CLEAR:  next_st.pin_out[i] = 1'b0;
                CCT_OUT_SET:    next_st.pin_out[i] = 1'b1;
              endcase
            end
          end
        end
        OFS_COUNTER:   next_st.counter  = req.wdata; // [R1] [R9]
        OFS_SYS_CTRL:  next_st.sys_ctrl = req.wdata[7:0] & SYS_CTRL_MASK;
        OFS_OUT_ACT:   next_st.out_act  = req.wdata;
        OFS_EDGE_SEL:  next_st.edge_sel = req.wdata;
        OFS_IRQ_MASK:  next_st.irq_mask = req.wdata[IRQ_W-1:0];
        OFS_PRESCALE:  next_st.prescale = req.wdata[2:0] & PRESCALE_MASK;
        OFS_ACC_CTRL:  next_st.acc_ctrl = req.wdata[7:0] & ACC_CTRL_MASK;
        OFS_ACC_COUNT: next_st.acc_count = req.wdata; // [R9]
        default: begin
          if (ch_sel) begin
            next_st.ch_val[ch_idx] = req.wdata; // [R9] [R15]
          end
        end
      endcase
    end

    // Write-one-to-clear; a new event wins over the clear
    if (req.wr && req.addr == OFS_IRQ_STAT) begin
      next_st.irq_stat = (st.irq_stat & ~req.wdata[IRQ_W-1:0]) | events;
    end else begin
      next_st.irq_stat = st.irq_stat | events;
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

    next_st.rdata = 16'h0000;
    if (req.rd) begin
      unique case (req.addr)
        OFS_FUNC_SEL:  next_st.rdata = {8'h00, st.func_sel};
        OFS_COUNTER:   next_st.rdata = st.counter;
        OFS_SYS_CTRL:  next_st.rdata = {8'h00, st.sys_ctrl};
        OFS_OUT_ACT:   next_st.rdata = st.out_act;
        OFS_EDGE_SEL:  next_st.rdata = st.edge_sel;
        OFS_IRQ_MASK:  next_st.rdata = 16'(st.irq_mask);
        OFS_PRESCALE:  next_st.rdata = {13'h0000, st.prescale};
        OFS_IRQ_STAT:  next_st.rdata = 16'(st.irq_stat);
        OFS_ACC_CTRL:  next_st.rdata = {8'h00, st.acc_ctrl};
        OFS_ACC_COUNT: next_st.rdata = st.acc_count;
        OFS_MODE_IN:   next_st.rdata = {14'h0000, st.mode_sync2};
        default: begin
          if (ch_sel) begin
            next_st.rdata = st.ch_val[ch_idx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o          = st.rdata;
  assign channel_pin_o    = st.pin_out;
  assign channel_pin_oe_o = st.pin_oe;
  assign irq_o            = st.irq;

  sequence cap_edge_s(int k);
    !st.func_sel[k] && st.sys_ctrl[RUN_EN_BIT] && !req.wr
      && edge_hit(st.edge_sel[2*k +: 2], st.pin_prev[k], st.sync2[k]);
  endsequence

  cnt_halt_off_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!st.sys_ctrl[RUN_EN_BIT] && !req.wr) |=> $stable(st.counter))
    else $error("Counter moved while disabled"); // [R13]
  frz_stop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (mode.freeze && st.sys_ctrl[FRZ_STOP_BIT]) |-> !run)
    else $error("Counter runs in freeze with stop bit"); // [R11]
  wait_stop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (mode.wait_mode && st.sys_ctrl[WAIT_STOP_BIT]) |-> !run)
    else $error("Counter runs in wait with stop bit"); // [R12]
  cnt_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tick && !(req.wr && req.addr == OFS_COUNTER)) |=> st.counter == $past(st.counter) + 16'h0001)
    else $error("Counter did not step or wrap"); // [R1]
  cnt_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (req.wr && req.addr == OFS_COUNTER) |=> st.counter == $past(req.wdata))
    else $error("Counter write lost"); // [R9]
  cap0_latch_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cap_edge_s(0) |=> st.ch_val[0] == $past(st.counter) && st.irq_stat[0])
    else $error("Channel 0 capture missed"); // [R3]
  cap_no_out_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !st.func_sel[3] |=> !channel_pin_oe_o[3] || $past(st.func_sel[3]))
    else $error("Capture channel drives its pin"); // [R14]
  cmp_match_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st.func_sel[4] && tick && st.counter + 16'h0001 == st.ch_val[4]) |=> st.irq_stat[4])
    else $error("Compare match flag missing"); // [R4]
  acc_event_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st.acc_ctrl[ACC_EN_BIT] && !st.acc_ctrl[ACC_MODE_BIT] && !req.wr
      && edge_hit({~st.acc_ctrl[ACC_EDGE_BIT], st.acc_ctrl[ACC_EDGE_BIT]}, acc_prev, acc_in))
    |=> st.acc_count == $past(st.acc_count) + 16'h0001)
    else $error("Accumulator missed a channel 7 edge"); // [R5]
  irq_level_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ##1 irq_o == |($past(next_st.irq_stat) & $past(next_st.irq_mask)))
    else $error("Interrupt output wrong"); // [R2]

endmodule : cct_timer

`default_nettype wire

// ### rtl/cct_pkg.sv
// Package with register map, field layout and types of the capture/compare timer
// Overview of operation
// [R1] 16-bit software-settable up-counter advances on prescaler output from module clock.
// [R2] Eight independent channels, each input capture or output compare on own pin.
// [R3] Capture channel detects selected pin edge and records the counter value.
// [R4] Compare channel changes its pin or flags a delay when counter matches value.
// [R5] 16-bit pulse accumulator works as event counter or gated time accumulator.
// [R6] Event-counting accumulator takes its input from the channel 7 pin.
// [R7] Channel 7 pin may serve as accumulator input besides capture/compare.
// [R8] Exactly eight pins, one per channel, numbered 0 to 7.
// [R9] Software accesses 16-bit counter and channel registers in one full-width cycle.
// [R10] Stop mode with clocks halted leaves the timer inactive, counter frozen.
// [R11] Counter runs in freeze mode unless the freeze-stop bit is set.
// [R12] Counters run in wait mode unless the wait-stop bit is set. The event-mode accumulator ignores the bit and keeps counting.
// [R13] Counter runs while timer enable is 1 and stops when it is 0.
// [R14] Function select bit: 0 input capture, 1 output compare.
// [R15] Counter wraps from 0xFFFF to zero; each channel has a 16-bit value register.
`default_nettype none

package cct_pkg;

  localparam int unsigned NUM_CH = 8;
  localparam int unsigned AW     = 8;

  // Register offsets
  localparam logic [AW-1:0] OFS_FUNC_SEL  = 8'h00;
  localparam logic [AW-1:0] OFS_FORCE     = 8'h01;
  localparam logic [AW-1:0] OFS_COUNTER   = 8'h04;
  localparam logic [AW-1:0] OFS_SYS_CTRL  = 8'h06;
  localparam logic [AW-1:0] OFS_OUT_ACT   = 8'h08;
  localparam logic [AW-1:0] OFS_EDGE_SEL  = 8'h0A;
  localparam logic [AW-1:0] OFS_IRQ_MASK  = 8'h0C;
  localparam logic [AW-1:0] OFS_PRESCALE  = 8'h0D;
  localparam logic [AW-1:0] OFS_IRQ_STAT  = 8'h0E;
  localparam logic [AW-1:0] OFS_CH_BASE   = 8'h10;
  localparam logic [AW-1:0] OFS_ACC_CTRL  = 8'h20;
  localparam logic [AW-1:0] OFS_ACC_COUNT = 8'h22;
  localparam logic [AW-1:0] OFS_MODE_IN   = 8'h30;

  // timer_system_control fields
  localparam int unsigned RUN_EN_BIT    = 7;
  localparam int unsigned WAIT_STOP_BIT = 6;
  localparam int unsigned FRZ_STOP_BIT  = 5;
  localparam logic [7:0] SYS_CTRL_MASK  = 8'hE0;
  localparam logic [7:0] SYS_CTRL_RESET = 8'h00;

  // Accumulator control fields
  localparam int unsigned ACC_EN_BIT   = 6;
  localparam int unsigned ACC_MODE_BIT = 5;
  localparam int unsigned ACC_EDGE_BIT = 4;
  localparam logic [7:0] ACC_CTRL_MASK = 8'h70;

  // Interrupt status layout: channel flags 7:0, overflow 8, accumulator 9, acc overflow 10
  localparam int unsigned IRQ_W       = 11;
  localparam int unsigned IRQ_OVF_BIT = 8;
  localparam int unsigned IRQ_ACC_BIT = 9;
  localparam int unsigned IRQ_AOV_BIT = 10;

  localparam logic [2:0] PRESCALE_MASK = 3'h7;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;

  // Output compare actions
  typedef enum logic [1:0] {
    CCT_OUT_NONE   = 2'b00,
    CCT_OUT_TOGGLE = 2'b01,
    CCT_OUT_CLEAR  = 2'b10,
    CCT_OUT_SET    = 2'b11
  } cct_out_act_t;

  // Capture edges
  typedef enum logic [1:0] {
    CCT_EDGE_OFF  = 2'b00,
    CCT_EDGE_RISE = 2'b01,
    CCT_EDGE_FALL = 2'b10,
    CCT_EDGE_ANY  = 2'b11
  } cct_edge_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [15:0]   wdata;
    logic          wr;
    logic          rd;
  } cct_bus_req_t;

  typedef struct packed {
    logic freeze;
    logic wait_mode;
  } cct_mode_t;

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
  endfunction : edge_hit

endpackage : cct_pkg

`default_nettype wire

// ### rtl/cct_prescaler.sv
// Prescaler dividing the module clock by 2 to the power of the selected factor
`default_nettype none

module cct_prescaler
  import cct_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [2:0] factor_i,
  output logic            tick_o
);

  typedef struct packed {
    logic [6:0] div;
    logic       tick;
  } cct_psc_state_t;

  cct_psc_state_t st;
  cct_psc_state_t next_st;
  logic [6:0]     limit;

  always_comb begin
    limit   = 7'((8'h01 << factor_i) - 8'h01);
    next_st = st;
    next_st.tick = 1'b0;
    if (run_i) begin
      if (st.div >= limit) begin
        next_st.div  = 7'h00;
        next_st.tick = 1'b1; // [R1]
      end else begin
        next_st.div = st.div + 7'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Gated by run so a tick already in flight cannot step a halted counter
  assign tick_o = st.tick & run_i; // [R13]

  tick_needs_run_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    tick_o |-> $past(run_i)) else $error("Prescaler ticked while halted"); // [R13]

endmodule : cct_prescaler

`default_nettype wire

// ### tb/cct_pin_model.sv
// Far-side driver model of the timer's eight capture/compare pins
`default_nettype none

module cct_pin_model
  import cct_pkg::*;
(
  input  wire logic [7:0] level_i,
  input  wire logic [7:0] dut_pin_i,
  input  wire logic [7:0] dut_oe_i,
  output logic      [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Device wins where it drives, so a compare pin with an output action never reads the bench level
  assign pin_o = (dut_oe_i & dut_pin_i) | (~dut_oe_i & level_i);

endmodule : cct_pin_model

`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of the capture/compare timer over its register port
`default_nettype none

module tb
  import cct_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic          ref_clk_i;
  logic          rst_i;
  logic [AW-1:0] addr_i;
  logic [15:0]   wdata_i;
  logic          wr_i;
  logic          rd_i;
  logic [15:0]   rdata_o;
  logic          freeze_i;
  logic          wait_mode_i;
  logic [7:0]    pin_lvl;
  logic [7:0]    pin_wire;
  logic [7:0]    pin_out;
  logic [7:0]    pin_oe;
  logic          irq_o;
  logic [15:0]   v;
  logic [15:0]   a;
  logic [15:0]   b;
  int            n_mismatch;
  int            checks_done;

  cct_timer dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .freeze_i(freeze_i),
    .wait_mode_i(wait_mode_i), .channel_pin_i(pin_wire), .channel_pin_o(pin_out),
    .channel_pin_oe_o(pin_oe), .irq_o(irq_o)
  );

  cct_pin_model pin_u (
    .level_i(pin_lvl), .dut_pin_i(pin_out), .dut_oe_i(pin_oe), .pin_o(pin_wire)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Whole-word accesses only; split bytes could tear a running count
  task automatic wr(input logic [AW-1:0] ad, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i  <= ad;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] ad, output logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= ad;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata_o;
  endtask : rd

  // Two counter reads taken 16 edges apart
  task automatic diff(input logic [15:0] exp);
    logic [15:0] c0;
    logic [15:0] c1;
    repeat (4) @(posedge ref_clk_i);
    rd(OFS_COUNTER, c0);
    repeat (14) @(posedge ref_clk_i);
    rd(OFS_COUNTER, c1);
    chk(c1 - c0, exp);
  endtask : diff

  task automatic pin_set(input logic [7:0] lv, input int hold);
    @(posedge ref_clk_i);
    pin_lvl <= lv;
    repeat (hold) @(posedge ref_clk_i);
  endtask : pin_set

  initial begin
    rst_i = 1'b1;
    addr_i = '0;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    freeze_i = 1'b0;
    wait_mode_i = 1'b0;
    pin_lvl = 8'h00;
    n_mismatch = 0;
    checks_done = 0;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(OFS_SYS_CTRL, v); chk(v, 16'h0000);
    rd(OFS_FUNC_SEL, v); chk(v, 16'h0000);
    rd(OFS_FORCE, v); chk(v, 16'h0000);
    rd(8'h3E, v); chk(v, 16'h0000);
    wr(OFS_COUNTER, 16'h1234);
    diff(16'h0000);
    rd(OFS_COUNTER, v); chk(v, 16'h1234);
    wr(OFS_SYS_CTRL, 16'h0080);
    diff(16'h0010);
    wr(OFS_PRESCALE, 16'h0002);
    diff(16'h0004);
    wr(OFS_PRESCALE, 16'h0000);
    wr(OFS_SYS_CTRL, 16'h00A0);
    @(posedge ref_clk_i);
    freeze_i <= 1'b1;
    diff(16'h0000);
    wr(OFS_SYS_CTRL, 16'h0080);
    diff(16'h0010);
    rd(OFS_MODE_IN, v); chk(v, 16'h0002);
    freeze_i <= 1'b0;
    wr(OFS_SYS_CTRL, 16'h00C0);
    @(posedge ref_clk_i);
    wait_mode_i <= 1'b1;
    diff(16'h0000);
    wr(OFS_SYS_CTRL, 16'h0080);
    diff(16'h0010);
    wait_mode_i <= 1'b0;
    // Overflow raises the masked level interrupt until cleared
    wr(OFS_IRQ_STAT, 16'h07FF);
    wr(OFS_IRQ_MASK, 16'h0100);
    wr(OFS_COUNTER, 16'hFFF0);
    repeat (2) @(posedge ref_clk_i);
    chk({15'h0000, irq_o}, 16'h0000);
    repeat (30) @(posedge ref_clk_i);
    chk({15'h0000, irq_o}, 16'h0001);
    rd(OFS_IRQ_STAT, v); chk(v & 16'h0100, 16'h0100);
    wr(OFS_IRQ_STAT, 16'h0100);
    repeat (2) @(posedge ref_clk_i);
    chk({15'h0000, irq_o}, 16'h0000);
    // Ch0 rise, ch1 fall, ch2 any, ch3 off
    wr(OFS_EDGE_SEL, 16'h0039);
    wr(OFS_IRQ_STAT, 16'h07FF);
    rd(OFS_COUNTER, a);
    pin_set(8'h0F, 6);
    pin_set(8'h00, 6);
    rd(OFS_COUNTER, b);
    rd(OFS_IRQ_STAT, v); chk(v & 16'h000F, 16'h0007);
    rd(OFS_CH_BASE, v); chk({15'h0000, (v >= a) && (v <= b)}, 16'h0001);
    rd(OFS_CH_BASE + 8'h02, v); chk({15'h0000, (v >= a) && (v <= b)}, 16'h0001);
    // Ch4 toggle, ch5 clear, ch6 set, ch7 no pin action
    wr(OFS_FUNC_SEL, 16'h00F0);
    wr(OFS_OUT_ACT, 16'h3900);
    wr(OFS_COUNTER, 16'h0100);
    for (int i = 4; i < 8; i++) begin
      wr(OFS_CH_BASE + AW'(2 * i), 16'h0120);
    end
    wr(OFS_IRQ_STAT, 16'h07FF);
    repeat (60) @(posedge ref_clk_i);
    chk({13'h0000, pin_out[6:4]}, 16'h0005);
    chk({12'h000, pin_oe[7:4]}, 16'h0007);
    rd(OFS_IRQ_STAT, v); chk(v & 16'h00F0, 16'h00F0);
    wr(OFS_FORCE, 16'h0010);
    repeat (2) @(posedge ref_clk_i);
    chk({15'h0000, pin_out[4]}, 16'h0000);
    // Pin 7 back to input; event count on rising edges
    wr(OFS_FUNC_SEL, 16'h0000);
    wr(OFS_OUT_ACT, 16'h0000);
    wr(OFS_ACC_CTRL, 16'h0050);
    wr(OFS_ACC_COUNT, 16'h0000);
    wr(OFS_IRQ_STAT, 16'h07FF);
    repeat (3) begin
      pin_set(8'h80, 4);
      pin_set(8'h00, 4);
    end
    repeat (6) @(posedge ref_clk_i);
    rd(OFS_ACC_COUNT, v); chk(v, 16'h0003);
    rd(OFS_IRQ_STAT, v); chk(v & 16'h0200, 16'h0200);
    // Gated mode: high gate of 23 cycles (20-cycle hold plus the status read), sync slack allowed
    wr(OFS_ACC_CTRL, 16'h0060);
    wr(OFS_ACC_COUNT, 16'h0000);
    wr(OFS_IRQ_STAT, 16'h07FF);
    pin_set(8'h80, 20);
    rd(OFS_IRQ_STAT, v); chk(v & 16'h0200, 16'h0000);
    pin_set(8'h00, 6);
    rd(OFS_ACC_COUNT, v); chk({15'h0000, (v >= 16) && (v <= 24)}, 16'h0001);
    rd(OFS_IRQ_STAT, v); chk(v & 16'h0200, 16'h0200);
    print_verdict();
  end

  // Whole run is well under 1500 cycles
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_mismatch++;
    print_verdict();
  end

endmodule : tb

`default_nettype wire
